// ===== hdl/timer_event_pkg.sv
// Register map, field positions and constants of the timer/event counter
package timer_event_pkg;
  localparam logic [7:0] off_count = 8'h00;
  localparam logic [7:0] off_control = 8'h04;
  localparam logic [7:0] off_irq_ctrl = 8'h08;
  localparam logic [7:0] off_power = 8'h0c;
  localparam logic [7:0] off_pin = 8'h10;
  localparam int ctl_prescale_lsb = 0;
  localparam int ctl_edge_pol = 3;
  localparam int ctl_run = 4;
  localparam int ctl_mode_lsb = 6;
  localparam int irq_global_en = 0;
  localparam int irq_ovf_en = 2;
  localparam int irq_ovf_flag = 5;
  localparam logic [1:0] mode_event = 2'h1;
  localparam logic [1:0] mode_timer = 2'h2;
  localparam logic [1:0] mode_capture = 2'h3;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] irq_ctrl_mask = 8'h25;
  localparam logic [7:0] overflow_vector = 8'h08;
  localparam logic [7:0] ext_vector = 8'h04;
endpackage

// ===== hdl/timer_event_counter_io.sv
// Timer/event counter with shared pin input, APB register slave and wake-up
// What this block does
// - Event and capture modes take their input from the shared timer pin.
// - Pull-high on the timer pin follows pin register bit 0 in every mode.
// - Timer mode counts the prescaled internal clock; full count raises interrupt request.
// - Capture mode counts the internal clock only while pin level is active.
// - Pin changes are seen two clock edges later, through the pin synchroniser.
// - Counting pauses during counter reads and preload writes.
// - Counter and preload hold no reset value.
// - Control bit 4 starts the counter when set, stops it when cleared.
// - Each overflow sets the overflow request flag.
// - Interrupt output only with the overflow interrupt enable set.
// - Overflow during power-down with the request flag clear gives wake-up regardless of interrupt enable.
// - Event counting continues during power-down.
// - Event mode counts rising edges with polarity low, falling with it high.
// - On overflow the counter reloads the preload value and keeps counting.
// - Capture mode clears the run bit when the pin returns to idle level.
// - Serviced overflow vectors to 08H below the external interrupt.
`timescale 1ns/1ps
module timer_event_counter_io (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin,
  input wire logic ext_irq_pending,
  output logic pin_pull_high,
  output logic timer_irq,
  output logic wake_up,
  output logic [7:0] irq_vector
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] count_q;
  logic [7:0] preload_q;
  logic [7:0] control_q;
  logic overflow_irq_enable_q;
  logic global_irq_enable_q;
  logic overflow_request_flag_q;
  logic power_down_q;
  logic pull_enable_q;
  logic pin_dir_input_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic [7:0] presc_q;
  logic capture_armed_q;
  logic count_run_bit;
  logic edge_polarity_bit;
  logic [1:0] mode;
  logic access;
  logic wr;
  logic rd;
  logic inhibit;
  logic pin_rise;
  logic pin_fall;
  logic tick_int;
  logic step;
  logic overflow;
  logic pin_active;
  logic pin_mode;
  logic wr_count;
  logic wr_control;
  logic wr_irq;
  logic wr_power;
  logic wr_pin;
  logic rd_count;
  logic [31:0] rdata_d;
  logic rerr_d;

  assign count_run_bit = control_q[timer_event_pkg::ctl_run];
  assign edge_polarity_bit = control_q[timer_event_pkg::ctl_edge_pol];
  assign mode = control_q[timer_event_pkg::ctl_mode_lsb +: 2];
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = psel & ~pwrite;
  assign wr_count = wr & (paddr == timer_event_pkg::off_count);
  assign wr_control = wr & (paddr == timer_event_pkg::off_control);
  assign wr_irq = wr & (paddr == timer_event_pkg::off_irq_ctrl);
  assign wr_power = wr & (paddr == timer_event_pkg::off_power);
  assign wr_pin = wr & (paddr == timer_event_pkg::off_pin);
  assign rd_count = rd & (paddr == timer_event_pkg::off_count);
  assign pin_mode = (mode == timer_event_pkg::mode_event) |
                    (mode == timer_event_pkg::mode_capture);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= timer_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end
  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;
  assign pin_active = edge_polarity_bit ? pin_sync_q : ~pin_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock prescaler, ratio 2^(n+1)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 8'h00;
    end else begin
      presc_q <= presc_q + 8'h01;
    end
  end
  always_comb begin
    logic [2:0] sel;
    sel = control_q[timer_event_pkg::ctl_prescale_lsb +: 3];
    tick_int = &(presc_q | ~((8'h02 << sel) - 8'h01));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count step selection
  assign inhibit = rd_count | wr_count;
  always_comb begin
    step = 1'b0;
    case (mode)
      timer_event_pkg::mode_event: begin
        step = edge_polarity_bit ? pin_fall : pin_rise;
      end
      timer_event_pkg::mode_timer: begin
        step = tick_int & ~power_down_q;
      end
      timer_event_pkg::mode_capture: begin
        step = tick_int & capture_armed_q & pin_active & ~power_down_q;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    step = step & count_run_bit & ~inhibit;
  end
  assign overflow = step & (count_q == 8'hff);

  // No reset on counter and preload
  always_ff @(posedge pclk) begin
    if (wr_count) begin
      preload_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk) begin
    if (wr_count && !count_run_bit) begin
      count_q <= pwdata[7:0];
    end else if (overflow) begin
      count_q <= preload_q;
    end else if (step) begin
      count_q <= count_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and capture sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= timer_event_pkg::control_reset;
      capture_armed_q <= 1'b0;
    end else begin
      if (wr_control) begin
        control_q <= pwdata[7:0];
        capture_armed_q <= 1'b0;
      end else if (mode == timer_event_pkg::mode_capture && count_run_bit) begin
        if (!capture_armed_q && pin_active && pin_prev_q != pin_sync_q) begin
          capture_armed_q <= 1'b1;
        end else if (capture_armed_q && !pin_active) begin
          control_q[timer_event_pkg::ctl_run] <= 1'b0;
          capture_armed_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt control; a hardware overflow beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
      overflow_request_flag_q <= 1'b0;
    end else begin
      if (wr_irq) begin
        overflow_irq_enable_q <= pwdata[timer_event_pkg::irq_ovf_en];
        global_irq_enable_q <= pwdata[timer_event_pkg::irq_global_en];
        overflow_request_flag_q <= pwdata[timer_event_pkg::irq_ovf_flag];
      end
      if (overflow) begin
        overflow_request_flag_q <= 1'b1;
      end
    end
  end

  // Power-down state, left by a waking overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_q <= 1'b0;
    end else if (wr_power) begin
      power_down_q <= pwdata[0];
    end else if (overflow && !overflow_request_flag_q) begin
      power_down_q <= 1'b0;
    end
  end

  // Pin configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_enable_q <= 1'b0;
      pin_dir_input_q <= 1'b0;
    end else if (wr_pin) begin
      pull_enable_q <= pwdata[0];
      pin_dir_input_q <= pwdata[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pull_high <= 1'b0;
      timer_irq <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      pin_pull_high <= pull_enable_q;
      timer_irq <= overflow_request_flag_q & overflow_irq_enable_q &
                   global_irq_enable_q;
      wake_up <= power_down_q & overflow & ~overflow_request_flag_q;
    end
  end

  // Vector of the request served first; the external one has priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector <= 8'h00;
    end else if (ext_irq_pending) begin
      irq_vector <= timer_event_pkg::ext_vector;
    end else if (overflow_request_flag_q & overflow_irq_enable_q) begin
      irq_vector <= timer_event_pkg::overflow_vector;
    end else begin
      irq_vector <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and error decode of the setup cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    rerr_d = 1'b0;
    case (paddr)
      timer_event_pkg::off_count: begin
        rdata_d[7:0] = count_q;
      end
      timer_event_pkg::off_control: begin
        rdata_d[7:0] = control_q;
      end
      timer_event_pkg::off_irq_ctrl: begin
        rdata_d[timer_event_pkg::irq_global_en] = global_irq_enable_q;
        rdata_d[timer_event_pkg::irq_ovf_en] = overflow_irq_enable_q;
        rdata_d[timer_event_pkg::irq_ovf_flag] = overflow_request_flag_q;
      end
      timer_event_pkg::off_power: begin
        rdata_d[0] = power_down_q;
      end
      timer_event_pkg::off_pin: begin
        rdata_d[0] = pull_enable_q;
        rdata_d[1] = pin_dir_input_q;
        rdata_d[2] = pin_sync_q & pin_mode;
      end
      default: begin
        rerr_d = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        prdata <= rdata_d;
        pslverr <= rerr_d;
      end
    end
  end
endmodule

// ===== verification/timer_event_checker.sv
// Port-level assertions of the timer/event counter
`timescale 1ns/1ps
module timer_event_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_irq_pending,
  input wire logic pin_pull_high,
  input wire logic timer_irq,
  input wire logic wake_up,
  input wire logic [7:0] irq_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && pready;
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready missing in access phase");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  bad_addr_a: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  vec_ext_a: assert property (ext_irq_pending |=> irq_vector == 8'h04)
    else $error("external vector not first");
  vec_timer_a: assert property (timer_irq |-> irq_vector != 8'h00)
    else $error("timer request without vector");
  irq_mask_a: assert property (acc && pwrite && paddr == 8'h08 && !pwdata[2]
    |-> ##2 !timer_irq)
    else $error("timer interrupt while disabled");
  wake_pulse_a: assert property (wake_up |=> !wake_up)
    else $error("wake-up longer than one cycle");
  pull_hold_a: assert property (!$past(acc && pwrite && paddr == 8'h10)
    |=> $stable(pin_pull_high))
    else $error("pull-high changed without write");
  pull_set_a: assert property (acc && pwrite && paddr == 8'h10
    |-> ##2 pin_pull_high == $past(pwdata[0], 2))
    else $error("pull-high not written");
endmodule
bind timer_event_counter_io timer_event_checker checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .ext_irq_pending(ext_irq_pending),
  .pin_pull_high(pin_pull_high), .timer_irq(timer_irq), .wake_up(wake_up),
  .irq_vector(irq_vector));

// ===== verification/pin_source.sv
// Logic source driving the shared timer pin
`timescale 1ns/1ps
module pin_source #(parameter int half = 8) (
  input wire logic pclk,
  input wire logic burst,
  output logic timer_pin
);
  int cnt = 0;
  initial timer_pin = 1'b1;
  // Toggles during a burst, otherwise rests at the pulled-high level
  always @(posedge pclk) begin
    if (!burst) begin
      cnt <= 0;
      timer_pin <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      if (cnt % half == half - 1) timer_pin <= ~timer_pin;
    end
  end
endmodule

// ===== verification/test_timer_event_counter_io.sv
// Self-checking bench for the timer/event counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_timer_event_counter_io;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_irq_pending = 0, burst = 0;
  logic [7:0] paddr = 8'h00, irq_vector;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic se, timer_pin, pready, pslverr, pin_pull_high, timer_irq, wake_up;
  int fails = 0, tests_run = 0, wakes = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (wake_up === 1'b1) wakes++;
  timer_event_counter_io timer_event_counter_io_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_pin(timer_pin), .ext_irq_pending(ext_irq_pending),
    .pin_pull_high(pin_pull_high), .timer_irq(timer_irq), .wake_up(wake_up),
    .irq_vector(irq_vector));
  pin_source pin_source_i (.pclk(pclk), .burst(burst), .timer_pin(timer_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata; se = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic pulse(input int n);
    @(posedge pclk);
    burst <= 1;
    repeat (n) @(posedge pclk);
    burst <= 0;
    repeat (12) @(posedge pclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(0, timer_event_pkg::off_control, 0);
    `CHK("control", 8'h00, rv[7:0])
    apb(0, 8'h20, 0);
    `CHK("slverr", 1'b1, se)
    apb(1, timer_event_pkg::off_pin, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK("pull", 1'b1, pin_pull_high)
  endtask
  task t_event_wake;
    apb(1, timer_event_pkg::off_irq_ctrl, 0);
    apb(1, timer_event_pkg::off_count, 32'hfe);
    apb(1, timer_event_pkg::off_control, 32'h58);
    apb(1, timer_event_pkg::off_power, 32'h1);
    pulse(32);
    `CHK("wakes", 1, wakes)
    `CHK("irq off", 1'b0, timer_irq)
    apb(0, timer_event_pkg::off_irq_ctrl, 0);
    `CHK("flag", 1'b1, rv[5])
    apb(0, timer_event_pkg::off_power, 0);
    `CHK("awake", 1'b0, rv[0])
  endtask
  task t_no_wake;
    apb(1, timer_event_pkg::off_control, 0);
    apb(1, timer_event_pkg::off_irq_ctrl, 32'h20);
    apb(1, timer_event_pkg::off_count, 32'hfe);
    apb(1, timer_event_pkg::off_control, 32'h58);
    apb(1, timer_event_pkg::off_power, 32'h1);
    pulse(32);
    `CHK("no wake", 1, wakes)
    apb(1, timer_event_pkg::off_power, 0);
  endtask
  task t_timer;
    logic [7:0] held;
    apb(1, timer_event_pkg::off_control, 0);
    apb(1, timer_event_pkg::off_irq_ctrl, 32'h05);
    apb(1, timer_event_pkg::off_count, 32'hfd);
    apb(1, timer_event_pkg::off_control, 32'h90);
    for (int i = 0; i < 100 && timer_irq !== 1'b1; i++) @(posedge pclk);
    `CHK("timer irq", 1'b1, timer_irq)
    `CHK("vector", 8'h08, irq_vector)
    ext_irq_pending <= 1;
    repeat (2) @(posedge pclk);
    `CHK("ext vector", 8'h04, irq_vector)
    ext_irq_pending <= 0;
    apb(1, timer_event_pkg::off_control, 0);
    apb(0, timer_event_pkg::off_count, 0);
    `CHK("reload", 1'b1, rv[7:0] >= 8'hfd)
    held = rv[7:0];
    apb(0, timer_event_pkg::off_count, 0);
    `CHK("stopped", held, rv[7:0])
  endtask
  task t_rise;
    apb(1, timer_event_pkg::off_control, 0);
    apb(1, timer_event_pkg::off_count, 32'h0);
    apb(1, timer_event_pkg::off_control, 32'h50);
    pulse(32);
    apb(1, timer_event_pkg::off_control, 0);
    apb(0, timer_event_pkg::off_count, 0);
    `CHK("rising", 8'h02, rv[7:0])
  endtask
  task t_capture;
    apb(1, timer_event_pkg::off_count, 0);
    apb(1, timer_event_pkg::off_control, 32'hd0);
    pulse(12);
    apb(0, timer_event_pkg::off_control, 0);
    `CHK("run clear", 1'b0, rv[4])
    apb(0, timer_event_pkg::off_count, 0);
    `CHK("width", 1'b1, rv[7:0] != 0 && rv[7:0] < 8)
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_event_wake();
    t_no_wake();
    t_timer();
    t_capture();
    t_rise();
    wrap_up();
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule
